/* cprc_pkg.sv */
// Package with register map, field positions and mode encodings of the pump controller.
package cprc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed offsets 0x95 and 0x96 are not word aligned, so they are indices.
  localparam logic [7:0] CPRC_IDX_MODE    = 8'h95;
  localparam logic [7:0] CPRC_IDX_DIVISOR = 8'h96;
  localparam int         CPRC_ADDR_W      = 12;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CPRC_BIT_ENABLE     = 0;
  localparam int CPRC_BIT_FORCE_ON   = 1;
  localparam int CPRC_BIT_AUTO       = 2;
  localparam int CPRC_BIT_AUTO_STATE = 3;
  localparam logic [2:0] CPRC_MODE_RESET    = 3'h0;
  localparam logic [7:0] CPRC_DIVISOR_RESET = 8'h00;

  // ****************************************************************
  // Bus responses
  // ****************************************************************
  localparam logic [1:0] CPRC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CPRC_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Decoded supply states
  // ****************************************************************
  typedef enum logic [1:0] {
    CPRC_OFF       = 2'h0,
    CPRC_REG_ONLY  = 2'h1,
    CPRC_AUTOMATIC = 2'h3,
    CPRC_ALWAYS_ON = 2'h2
  } cprc_state_e;

endpackage : cprc_pkg

/* cprc_clock_divider.sv */
// Pump clock divider: divides by (256 - divisor) then by two.
`timescale 1ns/100ps
module cprc_clock_divider
  import cprc_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  output logic                  pump_clock_o,
  output logic                  tick_o
);

  logic [DIV_W-1:0] count_reg;
  logic [DIV_W-1:0] count_next;
  logic             phase_reg;
  logic             phase_next;
  logic             tick_reg;
  logic             tick_next;

  always_comb begin
    count_next = count_reg;
    phase_next = phase_reg;
    tick_next  = 1'b0;
    if (!run_i) begin
      count_next = divisor_i;
      phase_next = 1'b0;
    end else if (count_reg == {DIV_W{1'b1}}) begin
      count_next = divisor_i;
      phase_next = ~phase_reg;
      tick_next  = 1'b1;
    end else begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_reg <= '0;
      phase_reg <= 1'b0;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      phase_reg <= phase_next;
      tick_reg  <= tick_next;
    end
  end

  assign pump_clock_o = phase_reg;
  assign tick_o       = tick_reg;

endmodule // cprc_clock_divider

/* cprc_top.sv */
// Charge pump and regulator control with an AXI4-Lite register slave.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module cprc_top
  import cprc_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic                   clock_i,
  input  wire logic                   reset_i,
  input  wire logic [CPRC_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic [CPRC_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  input  wire logic                   supply_above_threshold_i,
  output logic                        regulator_on_o,
  output logic                        pump_run_o,
  output logic                        pump_clock_o,
  output logic                        analog_supply_ready_o,
  output logic [1:0]                  supply_state_o
);

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function automatic logic [1:0] cprc_decode(input logic [CPRC_ADDR_W-1:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr[1:0] == 2'h0) begin
      if (addr[CPRC_ADDR_W-1:2] == {2'h0, CPRC_IDX_MODE}) begin
        sel = 2'h1;
      end else if (addr[CPRC_ADDR_W-1:2] == {2'h0, CPRC_IDX_DIVISOR}) begin
        sel = 2'h2;
      end
    end
    return sel;
  endfunction

  // ****************************************************************
  // Comparator input synchroniser
  // ****************************************************************
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       above_reg;
  logic       above_next;

  always_comb begin
    sync_next  = {sync_reg[1:0], supply_above_threshold_i};
    above_next = above_reg;
    if (sync_reg[1] == sync_reg[2]) begin
      above_next = sync_reg[2];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync_reg  <= 3'h0;
      above_reg <= 1'b0;
    end else begin
      sync_reg  <= sync_next;
      above_reg <= above_next;
    end
  end

  // ****************************************************************
  // Register slave
  // ****************************************************************
  logic [2:0]       mode_reg;
  logic [2:0]       mode_next;
  logic [DIV_W-1:0] divisor_reg;
  logic [DIV_W-1:0] divisor_next;
  logic             aw_held_reg;
  logic             aw_held_next;
  logic [1:0]       aw_sel_reg;
  logic [1:0]       aw_sel_next;
  logic             w_held_reg;
  logic             w_held_next;
  logic [31:0]      w_data_reg;
  logic [31:0]      w_data_next;
  logic             w_lane0_reg;
  logic             w_lane0_next;
  logic             bvalid_reg;
  logic             bvalid_next;
  logic [1:0]       bresp_reg;
  logic [1:0]       bresp_next;
  logic             rvalid_reg;
  logic             rvalid_next;
  logic [1:0]       rresp_reg;
  logic [1:0]       rresp_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             auto_state_reg;
  logic             aw_take;
  logic             w_take;
  logic             arready_reg;
  logic             arready_next;

  assign aw_take = s_axi_awvalid_i && !aw_held_reg && !bvalid_reg;
  assign w_take  = s_axi_wvalid_i && !w_held_reg && !bvalid_reg;

  always_comb begin
    mode_next    = mode_reg;
    divisor_next = divisor_reg;
    aw_held_next = aw_held_reg;
    aw_sel_next  = aw_sel_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (aw_take) begin
      aw_held_next = 1'b1;
      aw_sel_next  = cprc_decode(s_axi_awaddr_i);
    end
    if (w_take) begin
      w_held_next  = 1'b1;
      w_data_next  = s_axi_wdata_i;
      w_lane0_next = s_axi_wstrb_i[0];
    end
    if (aw_held_reg && w_held_reg) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (aw_sel_reg == 2'h0) ? CPRC_RESP_SLVERR : CPRC_RESP_OKAY;
      if (w_lane0_reg) begin
        if (aw_sel_reg == 2'h1) begin
          mode_next = w_data_reg[CPRC_BIT_AUTO:CPRC_BIT_ENABLE];
        end
        if (aw_sel_reg == 2'h2) begin
          divisor_next = w_data_reg[DIV_W-1:0];
        end
      end
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end else if (!rvalid_reg && s_axi_arvalid_i) begin
      rvalid_next = 1'b1;
      rdata_next  = 32'h0;
      rresp_next  = CPRC_RESP_OKAY;
      case (cprc_decode(s_axi_araddr_i))
        2'h1: begin
          rdata_next[CPRC_BIT_AUTO:CPRC_BIT_ENABLE] = mode_reg;
          rdata_next[CPRC_BIT_AUTO_STATE]           = auto_state_reg;
        end
        2'h2: begin
          rdata_next = 32'h0;
        end
        default: begin
          rresp_next = CPRC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mode_reg    <= CPRC_MODE_RESET;
      divisor_reg <= CPRC_DIVISOR_RESET;
      aw_held_reg <= 1'b0;
      aw_sel_reg  <= 2'h0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_lane0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= CPRC_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= CPRC_RESP_OKAY;
      rdata_reg   <= 32'h0;
    end else begin
      mode_reg    <= mode_next;
      divisor_reg <= divisor_next;
      aw_held_reg <= aw_held_next;
      aw_sel_reg  <= aw_sel_next;
      w_held_reg  <= w_held_next;
      w_data_reg  <= w_data_next;
      w_lane0_reg <= w_lane0_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign s_axi_awready_o = aw_held_reg;
  assign s_axi_wready_o  = w_held_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign s_axi_rdata_o   = rdata_reg;

  // Read address is accepted one cycle after it is offered, with its data.
  always_comb begin
    arready_next = !rvalid_reg && s_axi_arvalid_i;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      arready_reg <= 1'b0;
    end else begin
      arready_reg <= arready_next;
    end
  end

  // ****************************************************************
  // Mode decoding and pump control
  // ****************************************************************
  cprc_state_e state_reg;
  cprc_state_e state_next;
  logic        regulator_reg;
  logic        regulator_next;
  logic        pump_reg;
  logic        pump_next;
  logic        ready_reg;
  logic        ready_next;
  logic        auto_state_next;

  always_comb begin
    state_next      = CPRC_OFF;
    regulator_next  = 1'b0;
    pump_next       = 1'b0;
    ready_next      = 1'b0;
    auto_state_next = 1'b0;
    if (!mode_reg[CPRC_BIT_ENABLE]) begin
      state_next = CPRC_OFF;
    end else if (mode_reg[CPRC_BIT_FORCE_ON]) begin
      state_next = CPRC_ALWAYS_ON;
    end else if (mode_reg[CPRC_BIT_AUTO]) begin
      state_next = CPRC_AUTOMATIC;
    end else begin
      state_next = CPRC_REG_ONLY;
    end
    case (state_next)
      CPRC_OFF: begin
        regulator_next = 1'b0;
      end
      CPRC_REG_ONLY: begin
        regulator_next = 1'b1;
      end
      CPRC_AUTOMATIC: begin
        regulator_next  = 1'b1;
        pump_next       = !above_reg;
        ready_next      = 1'b1;
        auto_state_next = !above_reg;
      end
      CPRC_ALWAYS_ON: begin
        regulator_next = 1'b1;
        pump_next      = 1'b1;
        ready_next     = 1'b1;
      end
      default: begin
        regulator_next = 1'b0;
      end
    endcase
    regulator_next = regulator_next & mode_reg[CPRC_BIT_ENABLE];
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg      <= CPRC_OFF;
      regulator_reg  <= 1'b0;
      pump_reg       <= 1'b0;
      ready_reg      <= 1'b0;
      auto_state_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      regulator_reg  <= regulator_next;
      pump_reg       <= pump_next;
      ready_reg      <= ready_next;
      auto_state_reg <= auto_state_next;
    end
  end

  // ****************************************************************
  // Pump clock
  // ****************************************************************
  logic pump_clock_w;

  cprc_clock_divider #(
    .DIV_W (DIV_W)
  ) u_divider (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .run_i        (pump_reg),
    .divisor_i    (divisor_reg),
    .pump_clock_o (pump_clock_w),
    .tick_o       ()
  );

  assign regulator_on_o        = regulator_reg;
  assign pump_run_o            = pump_reg;
  assign pump_clock_o          = pump_clock_w;
  assign analog_supply_ready_o = ready_reg;
  assign supply_state_o        = state_reg;

endmodule // cprc_top

/* cprc_top_assertions.sv */
// Port level checker of the charge pump and regulator controller.
`timescale 1ns/100ps
module cprc_top_assertions
  import cprc_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        supply_above_threshold_i,
  input wire logic        regulator_on_o,
  input wire logic        pump_run_o,
  input wire logic        pump_clock_o,
  input wire logic        analog_supply_ready_o,
  input wire logic [1:0]  supply_state_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ****************************************************************
  // Supply states and pump control
  // ****************************************************************
  off_state_a: assert property (supply_state_o == CPRC_OFF |-> !regulator_on_o && !pump_run_o)
    else $error("off state drives the supply");
  reg_on_a: assert property (regulator_on_o == (supply_state_o != CPRC_OFF))
    else $error("regulator does not follow state");
  always_on_a: assert property (supply_state_o == CPRC_ALWAYS_ON |-> pump_run_o)
    else $error("pump stopped in always-on state");
  reg_only_a: assert property (supply_state_o == CPRC_REG_ONLY |-> !pump_run_o)
    else $error("pump runs in regulator-only state");
  auto_stop_a: assert property ((supply_state_o == CPRC_AUTOMATIC && supply_above_threshold_i)[*6]
    |-> !pump_run_o)
    else $error("pump runs above threshold");
  auto_run_a: assert property ((supply_state_o == CPRC_AUTOMATIC && !supply_above_threshold_i)[*6]
    |-> pump_run_o)
    else $error("pump stopped below threshold");
  supply_ready_a: assert property (analog_supply_ready_o ==
    (supply_state_o == CPRC_AUTOMATIC || supply_state_o == CPRC_ALWAYS_ON))
    else $error("availability does not follow state");
  clock_idle_a: assert property ((!pump_run_o)[*2] |-> !pump_clock_o)
    else $error("pump clock runs while pump stopped");
  // ****************************************************************
  // Register bus
  // ****************************************************************
  write_resp_a: assert property (s_axi_awready_o && s_axi_wready_o |=> s_axi_bvalid_o)
    else $error("write response late");
  read_accept_a: assert property ($rose(s_axi_rvalid_o) |-> s_axi_arready_o)
    else $error("read data without address accept");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
endmodule // cprc_top_assertions

bind cprc_top cprc_top_assertions u_cprc_top_assertions (.*);

/* cprc_supply_model.sv */
// Behavioural model of the supply comparator and the analog load rail.
`timescale 1ns/100ps
module cprc_supply_model (
  input  wire logic [15:0] vdd_mv_i,
  input  wire logic        regulator_on_i,
  output logic             above_o,
  output logic [15:0]      rail_mv_o
);
  assign above_o = vdd_mv_i > 16'h1004;
  assign rail_mv_o = regulator_on_i ? 16'h0ed8 : 16'h0000;
endmodule // cprc_supply_model

/* charge_pump_regulator_control_tb.sv */
// Self-checking bench of the charge pump and regulator controller.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t mismatch %0h vs %0h", $time, (a), (b)); end end
module charge_pump_regulator_control_tb;
  import cprc_pkg::*;
  localparam logic [11:0] A_MODE = 12'({CPRC_IDX_MODE, 2'b00});
  localparam logic [11:0] A_DIV  = 12'({CPRC_IDX_DIVISOR, 2'b00});
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [15:0] vdd_mv  = 16'h1194;
  logic        awready, wready, bvalid, arready, rvalid, above, reg_on, run, pclk, ready;
  logic [1:0]  bresp, rresp, state;
  logic [31:0] rdata;
  logic [15:0] rail_mv;
  int          error_cnt = 0;
  int          samples_checked = 0;
  initial forever #5 clock_i = ~clock_i;
  cprc_top u_cprc_top (
    .clock_i(clock_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .supply_above_threshold_i(above), .regulator_on_o(reg_on), .pump_run_o(run),
    .pump_clock_o(pclk), .analog_supply_ready_o(ready), .supply_state_o(state)
  );
  cprc_supply_model u_cprc_supply_model (
    .vdd_mv_i(vdd_mv), .regulator_on_i(reg_on), .above_o(above), .rail_mv_o(rail_mv)
  );
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_out();
    `CHK(1'b0, 1'b1)
    close_out();
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic ar_, wr_, bv;
    logic [1:0] r;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clock_i);
      ar_ = awready;
      wr_ = wready;
      bv = bvalid;
      r = bresp;
      @(posedge clock_i);
      if (ar_ === 1'b1) awvalid <= 1'b0;
      if (wr_ === 1'b1) wvalid <= 1'b0;
      if (bv === 1'b1) begin
        bready <= 1'b0;
        `CHK(r, er)
        return;
      end
    end
    t_out();
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic arr, rv;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clock_i);
      arr = arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock_i);
      if (arr === 1'b1) arvalid <= 1'b0;
      if (rv === 1'b1) begin
        rready <= 1'b0;
        return;
      end
    end
    t_out();
  endtask
  task automatic tog(output int n);
    logic p;
    p = pclk;
    n = 0;
    while (pclk === p) begin
      @(posedge clock_i);
      #1;
      n++;
      if (n > 600) t_out();
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    `CHK({state, reg_on, run, pclk, ready}, 6'h00)
    axi_rd(A_MODE, d, r);
    `CHK({r, d}, {CPRC_RESP_OKAY, 32'h0})
  endtask
  task automatic t_modes();
    logic [31:0] d;
    logic [1:0]  r;
    cprc_state_e st;
    // reserved code skipped, supply at 4.5V, above the 4.1V threshold
    for (int m = 0; m < 7; m++) begin
      axi_wr(A_MODE, 8'(m), 4'h1, CPRC_RESP_OKAY);
      wait_cyc(8);
      st = !m[0] ? CPRC_OFF : m[1] ? CPRC_ALWAYS_ON : m[2] ? CPRC_AUTOMATIC : CPRC_REG_ONLY;
      `CHK(state, st)
      `CHK(reg_on, m[0])
      `CHK(rail_mv, m[0] ? 16'h0ed8 : 16'h0000)
      `CHK(run, st == CPRC_ALWAYS_ON)
      `CHK(ready, st == CPRC_AUTOMATIC || st == CPRC_ALWAYS_ON)
      axi_rd(A_MODE, d, r);
      `CHK(d, {29'h0, 3'(m)})
    end
  endtask
  task automatic t_auto();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(A_MODE, 8'h05, 4'h1, CPRC_RESP_OKAY);
    vdd_mv <= 16'h0e10;
    wait_cyc(10);
    `CHK(run, 1'b1)
    axi_rd(A_MODE, d, r);
    `CHK(d, 32'h0000000d)
    vdd_mv <= 16'h1194;
    wait_cyc(10);
    `CHK(run, 1'b0)
    axi_rd(A_MODE, d, r);
    `CHK(d, 32'h00000005)
    vdd_mv <= 16'h0e10;
  endtask
  task automatic t_div();
    logic [7:0]  dv [2] = '{8'h9c, 8'hfc};
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    // documented divisor example among the values
    foreach (dv[i]) begin
      axi_wr(A_DIV, dv[i], 4'h1, CPRC_RESP_OKAY);
      tog(n);
      tog(n);
      `CHK(n, 256 - dv[i])
      axi_rd(A_DIV, d, r);
      `CHK(d, 32'h0)
    end
  endtask
  task automatic t_refuse();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(12'h100, 8'h01, 4'h1, CPRC_RESP_SLVERR);
    axi_wr(A_MODE, 8'h01, 4'h0, CPRC_RESP_OKAY);
    axi_rd(A_MODE, d, r);
    `CHK(d[2:0], 3'h5)
    axi_rd(12'h100, d, r);
    `CHK({r, d}, {CPRC_RESP_SLVERR, 32'h0})
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    wait_cyc(1);
    t_reset();
    t_modes();
    t_auto();
    t_div();
    t_refuse();
    close_out();
  end
endmodule // charge_pump_regulator_control_tb
